// [design/comparator_input_select_regs.sv]
// Operation
// RULE1: Per-bus master disable stops bus mastering.
// RULE2: Disabled bus ignores own channel selection.
// RULE3: Disable applies to bus currently selected.
// RULE4: Inactive comparator outputs stored inactive value.
// RULE5: Invert bit inverts result toward pin.
// RULE6: Three-bit capsense resistor select, bits 30:28.
// RULE7: Capsense resistor enable at bit 26.
// RULE8: Low-power sample source bit 24.
// RULE9: B divider reference select at bit 22.
// RULE10: Six-bit A divider source, bits 21:16.
// RULE11: Positive and negative eight-bit selects.
// RULE12: Codes below 0x20 are bus zero.
// RULE13: Codes 0x20 to 0x9f are shared banks.
// RULE14: High codes select fixed internal sources.
// RULE15: Software writes zero to reserved bits.
// RULE16: Read-only conflict when buses are shared.
// RULE17: Undefined select codes carry no meaning.
// RULE18: Enable bit zero activates the comparator.
`timescale 1ns/1ps
module comparator_input_select_regs (
  input  wire logic                                ref_clk,
  input  wire logic                                reset_n,
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [7:0]                          wb_adr_i,
  input  wire logic [3:0]                          wb_sel_i,
  input  wire logic [31:0]                         wb_dat_i,
  output wire logic [31:0]                         wb_dat_o,
  output wire logic                                wb_ack_o,
  output wire logic                                irq,
  input  wire logic                                comparatorRaw,
  input  wire logic                                comparatorReady,
  input  wire logic [comparator_pkg::HALF_COUNT-1:0] otherRequest,
  output wire logic [comparator_pkg::HALF_COUNT-1:0] busRequest,
  output wire logic [7:0]                          positiveInputSelect,
  output wire logic [7:0]                          negativeInputSelect,
  output wire logic [5:0]                          aDividerSource,
  output wire logic                                bDividerSource,
  output wire logic                                lowpowerSampleSource,
  output wire logic                                capsenseResistorEnable,
  output wire logic [2:0]                          capsenseResistorSelect,
  output wire logic                                comparatorEnable,
  output wire logic                                comparatorResult,
  output wire logic                                pinOutput
);
  import comparator_pkg::*;

  // Every flip-flop of the block lives in this one record.
  typedef struct packed {
    logic                  ack;        // Bus acknowledge, one cycle per access.
    logic [31:0]           rdata;      // Read data presented with ack.
    logic [31:0]           ctrl;       // Control register.
    logic [31:0]           inputSel;   // Input selection register.
    logic [2:0]            flags;      // Sticky interrupt flags.
    logic [2:0]            mask;       // Interrupt mask.
    logic                  active;     // Comparator active status.
    logic                  result;     // Comparator output after inactive substitution.
    logic                  pin;        // Value toward the general-purpose pin.
    logic [HALF_COUNT-1:0] request;    // Bus halves this comparator masters.
    logic [HALF_COUNT-1:0] conflict;   // Requested halves also wanted by others.
    logic                  irq;        // Interrupt line.
  } state_t;

  state_t                stateReg;      // Registered state.
  state_t                stateNext;     // Next state.
  logic                  access;        // A bus cycle is addressed to us.
  logic                  writeNow;      // The write takes effect on this edge.
  logic                  activeNext;    // Comparator active in the next cycle.
  logic                  resultNext;    // Comparator output in the next cycle.
  logic [2:0]            flagSet;       // Events raising flags this cycle.
  logic [2:0]            flagClear;     // Flags cleared by software this cycle.
  logic [HALF_COUNT-1:0] disableMask;   // Master disable per bus half.

  // Decoders for the positive and the negative select.
  select_decode_if posIf ();
  select_decode_if negIf ();

  assign posIf.code = stateReg.inputSel[POS_LSB +: 8];
  assign negIf.code = stateReg.inputSel[NEG_LSB +: 8];

  select_decoder posDecoder (
    .sel (posIf.decoder)
  );

  select_decoder negDecoder (
    .sel (negIf.decoder)
  );

  // Merges a bus write into a register byte by byte, holding reserved bits at zero.
  function automatic logic [31:0] applyWrite(input logic [31:0] oldValue, input logic [31:0] newValue,
                                             input logic [3:0] lanes, input logic [31:0] writeMask);
    logic [31:0] merged;
    merged = oldValue;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        merged[i*8 +: 8] = newValue[i*8 +: 8];
      end
    end
    return merged & writeMask;
  endfunction

  // One-hot bus half named by a decoded select, or nothing for a fixed source.
  function automatic logic [HALF_COUNT-1:0] halfBit(input input_kind_t kind, input logic [2:0] bus,
                                                    input logic half);
    logic [3:0] index;
    index = {bus, half};
    if (kind == INPUT_BUS) begin
      return 10'h001 << index;
    end
    return 10'h000;
  endfunction

  // Bus access, register updates, comparator output path and interrupt logic.
  always_comb begin
    stateNext   = stateReg;
    access      = wb_cyc_i & wb_stb_i;
    writeNow    = access & wb_we_i & stateReg.ack;
    disableMask = stateReg.ctrl[MASTER_DISABLE_LSB +: HALF_COUNT];
    flagSet     = 3'h0;
    flagClear   = 3'h0;

    // Answer one cycle after the request and drop ack the cycle after.
    stateNext.ack   = access & ~stateReg.ack;
    stateNext.rdata = 32'h0000_0000;
    if (access && !stateReg.ack && !wb_we_i) begin
      unique case (wb_adr_i)
        CTRL_OFFSET:         stateNext.rdata = stateReg.ctrl;
        INPUT_SELECT_OFFSET: stateNext.rdata = stateReg.inputSel;
        STATUS_OFFSET:       stateNext.rdata = {29'h0000_0000, |stateReg.conflict, stateReg.result,
                                                stateReg.active};
        FLAG_OFFSET:         stateNext.rdata = {29'h0000_0000, stateReg.flags};
        MASK_OFFSET:         stateNext.rdata = {29'h0000_0000, stateReg.mask};
        REQUEST_OFFSET:      stateNext.rdata = {22'h00_0000, stateReg.request};
        CONFLICT_OFFSET:     stateNext.rdata = {22'h00_0000, stateReg.conflict};
        // Unmapped offsets read as zero and still acknowledge.
        default:             stateNext.rdata = 32'h0000_0000;
      endcase
    end

    // Writes land on the edge that carries ack, as the master expects.
    if (writeNow) begin
      unique case (wb_adr_i)
        CTRL_OFFSET: begin
          stateNext.ctrl = applyWrite(stateReg.ctrl, wb_dat_i, wb_sel_i, CTRL_WRITE_MASK);
        end
        INPUT_SELECT_OFFSET: begin
          // RULE6: input fields stored masked
          // Reserved bits are dropped here, so a careless write cannot reach them.
          stateNext.inputSel = applyWrite(stateReg.inputSel, wb_dat_i, wb_sel_i, INPUT_WRITE_MASK);
        end
        FLAG_OFFSET: begin
          if (wb_sel_i[0]) begin
            flagClear = wb_dat_i[2:0];
          end
        end
        MASK_OFFSET: begin
          if (wb_sel_i[0]) begin
            stateNext.mask = wb_dat_i[2:0];
          end
        end
        // Read-only and unmapped offsets ignore writes.
        default: begin
        end
      endcase
    end

    // RULE18: enable activates comparator
    // The analog side reports readiness once warmed up; only then is the result trusted.
    activeNext = stateReg.ctrl[ENABLE_BIT] & comparatorReady;
    // RULE4: inactive value substitution
    resultNext = activeNext ? comparatorRaw : stateReg.ctrl[INACTIVE_BIT];
    stateNext.active = activeNext;
    stateNext.result = resultNext;
    // RULE5: optional pin inversion
    stateNext.pin = resultNext ^ stateReg.ctrl[INVERT_BIT];

    // RULE1: master disable gating
    // RULE3: applies to selected bus
    // RULE2: disabled bus only observed
    // A disabled half is never requested, so another peripheral's channel choice stands.
    stateNext.request = (halfBit(posIf.kind, posIf.bus, posIf.half) | halfBit(negIf.kind, negIf.bus, negIf.half))
                        & ~disableMask & {HALF_COUNT{stateReg.ctrl[ENABLE_BIT]}};
    // RULE16: bus conflict detection
    stateNext.conflict = stateReg.request & otherRequest;

    // Events raising the sticky flags.
    flagSet[EDGE_FLAG]     = activeNext & stateReg.active & (resultNext != stateReg.result);
    flagSet[WARMUP_FLAG]   = activeNext & ~stateReg.active;
    flagSet[CONFLICT_FLAG] = |stateReg.conflict;
    // An event in the same cycle as its clear wins over the clear.
    stateNext.flags = (stateReg.flags & ~flagClear) | flagSet;
    stateNext.irq   = |(stateNext.flags & stateNext.mask);
  end

  // State register with a constant asynchronous reset.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stateReg <= '{ack: 1'b0, rdata: 32'h0000_0000, ctrl: CTRL_RESET, inputSel: INPUT_RESET,
                    flags: 3'h0, mask: 3'h0, active: 1'b0, result: 1'b0, pin: 1'b0,
                    request: 10'h000, conflict: 10'h000, irq: 1'b0};
    end else begin
      stateReg <= stateNext;
    end
  end

  // All outputs come straight from the state record.
  assign wb_ack_o               = stateReg.ack;
  assign wb_dat_o               = stateReg.rdata;
  assign irq                    = stateReg.irq;
  assign busRequest             = stateReg.request;
  assign comparatorEnable       = stateReg.ctrl[ENABLE_BIT];
  assign comparatorResult       = stateReg.result;
  assign pinOutput              = stateReg.pin;
  // RULE11: input select fields
  assign positiveInputSelect    = stateReg.inputSel[POS_LSB +: 8];
  assign negativeInputSelect    = stateReg.inputSel[NEG_LSB +: 8];
  // RULE10: A divider source field
  assign aDividerSource         = stateReg.inputSel[A_DIV_LSB +: 6];
  // RULE9: B divider reference
  assign bDividerSource         = stateReg.inputSel[B_DIV_BIT];
  // RULE8: low-power sample source
  assign lowpowerSampleSource   = stateReg.inputSel[LOWPOWER_BIT];
  // RULE7: capsense resistor enable
  assign capsenseResistorEnable = stateReg.inputSel[CS_ENABLE_BIT];
  assign capsenseResistorSelect = stateReg.inputSel[CS_SELECT_LSB +: 3];

  // Bus handshake: ack is a single pulse, never high two cycles running.
  ack_single_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // A full-word write to the input selection register reads back masked.
  input_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE11
    (writeNow && wb_adr_i == INPUT_SELECT_OFFSET && wb_sel_i == 4'hF)
    |=> stateReg.inputSel == ($past(wb_dat_i) & INPUT_WRITE_MASK))
    else $error("input selection write not stored");

  master_disable_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE1
    (stateReg.request & $past(disableMask)) == 10'h000)
    else $error("disabled bus half was requested");

  inactive_value_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE4
    !stateReg.active |-> stateReg.result == $past(stateReg.ctrl[INACTIVE_BIT]))
    else $error("inactive output differs from inactive value");

  pin_invert_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE5
    ##1 stateReg.pin == (stateReg.result ^ $past(stateReg.ctrl[INVERT_BIT])))
    else $error("pin output inversion wrong");

  disable_inactive_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE18
    !stateReg.ctrl[ENABLE_BIT] |=> !stateReg.active && stateReg.request == 10'h000)
    else $error("comparator active while disabled");

  bus_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE12
    (posIf.code <= BUS0_LIMIT) |-> (posIf.kind == INPUT_BUS && posIf.bus == 3'h0
    && posIf.half == posIf.code[4] && posIf.channel == {1'b0, posIf.code[3:0]}))
    else $error("bus zero decode wrong");

  shared_bank_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE13
    (negIf.code >= SHARED_FIRST && negIf.code <= SHARED_LAST) |-> (negIf.kind == INPUT_BUS
    && negIf.bus == negIf.code[7:5] && negIf.half == (negIf.code[0] ^ ~negIf.code[5])))
    else $error("shared bank decode wrong");

  fixed_source_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE14
    (posIf.code == CODE_GROUND |-> posIf.kind == INPUT_GROUND)
    and (posIf.code == CODE_CONVERTER0 |-> posIf.kind == INPUT_CONVERTER0))
    else $error("fixed source decode wrong");

  conflict_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE16
    |stateReg.conflict |=> stateReg.flags[CONFLICT_FLAG])
    else $error("conflict flag not raised");

  irq_level_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    irq == |(stateReg.flags & stateReg.mask))
    else $error("interrupt line disagrees with flags and mask");

endmodule

// [pkg/comparator_pkg.sv]
// Shared constants and types of the comparator control and input selection block.
package comparator_pkg;

  // Register byte offsets on the register bus.
  localparam logic [7:0]  CTRL_OFFSET         = 8'h00;
  localparam logic [7:0]  INPUT_SELECT_OFFSET = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET       = 8'h08;
  localparam logic [7:0]  FLAG_OFFSET         = 8'h0C;
  localparam logic [7:0]  MASK_OFFSET         = 8'h18;
  localparam logic [7:0]  REQUEST_OFFSET      = 8'h20;
  localparam logic [7:0]  CONFLICT_OFFSET     = 8'h24;

  // Control register fields.
  localparam int          ENABLE_BIT          = 0;
  localparam int          INACTIVE_BIT        = 2;
  localparam int          INVERT_BIT          = 3;
  localparam int          MASTER_DISABLE_LSB  = 8;
  localparam int          HALF_COUNT          = 10;
  localparam logic [31:0] CTRL_WRITE_MASK     = 32'h0003_FF0D;
  localparam logic [31:0] CTRL_RESET          = 32'h0000_0000;

  // Input selection register fields.
  localparam int          POS_LSB             = 0;
  localparam int          NEG_LSB             = 8;
  localparam int          A_DIV_LSB           = 16;
  localparam int          B_DIV_BIT           = 22;
  localparam int          LOWPOWER_BIT        = 24;
  localparam int          CS_ENABLE_BIT       = 26;
  localparam int          CS_SELECT_LSB       = 28;
  localparam logic [31:0] INPUT_WRITE_MASK    = 32'h757F_FFFF;
  localparam logic [31:0] INPUT_RESET         = 32'h0000_0000;

  // Status and interrupt flag bits.
  localparam int          ACTIVE_BIT          = 0;
  localparam int          RESULT_BIT          = 1;
  localparam int          CONFLICT_BIT        = 2;
  localparam int          EDGE_FLAG           = 0;
  localparam int          WARMUP_FLAG         = 1;
  localparam int          CONFLICT_FLAG       = 2;

  // Input select code boundaries and fixed sources.
  localparam logic [7:0]  BUS0_LIMIT          = 8'h1F;
  localparam logic [7:0]  SHARED_FIRST        = 8'h20;
  localparam logic [7:0]  SHARED_LAST         = 8'h9F;
  localparam logic [7:0]  CODE_CONVERTER0     = 8'hF2;
  localparam logic [7:0]  CODE_CONVERTER1     = 8'hF3;
  localparam logic [7:0]  CODE_LOWPOWER       = 8'hFB;
  localparam logic [7:0]  CODE_DIV_B          = 8'hFC;
  localparam logic [7:0]  CODE_DIV_A          = 8'hFD;
  localparam logic [7:0]  CODE_SUPPLY         = 8'hFE;
  localparam logic [7:0]  CODE_GROUND         = 8'hFF;

  // Kind of source that an input select code names.
  typedef enum logic [3:0] {
    INPUT_BUS, INPUT_CONVERTER0, INPUT_CONVERTER1, INPUT_LOWPOWER, INPUT_DIV_B,
    INPUT_DIV_A, INPUT_SUPPLY, INPUT_GROUND, INPUT_UNDEFINED
  } input_kind_t;

endpackage

// [pkg/select_decode_if.sv]
`timescale 1ns/1ps
// Carries one input select code to its decoder and the decoded source back.
interface select_decode_if;
  import comparator_pkg::*;
  logic [7:0]  code;     // Raw select code.
  input_kind_t kind;     // Kind of source named by the code.
  logic [2:0]  bus;      // Analog bus number, 0 to 4.
  logic        half;     // Zero for the X half, one for the Y half.
  logic [4:0]  channel;  // Channel within the half.
  modport requester (output code, input kind, input bus, input half, input channel);
  modport decoder   (input code, output kind, output bus, output half, output channel);
endinterface

// [design/select_decoder.sv]
`timescale 1ns/1ps
// Combinational decoder of one input select code.
module select_decoder (
  select_decode_if.decoder sel
);
  import comparator_pkg::*;

  // Dedicated bus 0, the four shared banks and the fixed sources.
  always_comb begin
    sel.kind    = INPUT_UNDEFINED;
    sel.bus     = 3'h0;
    sel.half    = 1'b0;
    sel.channel = 5'h00;
    if (sel.code <= BUS0_LIMIT) begin
      // RULE12: dedicated bus zero
      sel.kind    = INPUT_BUS;
      sel.half    = sel.code[4];
      sel.channel = {1'b0, sel.code[3:0]};
    end else if (sel.code >= SHARED_FIRST && sel.code <= SHARED_LAST) begin
      // RULE13: shared bus banks
      // Banks 1 and 3 start on X, banks 2 and 4 on Y, so bit 5 flips the parity.
      sel.kind    = INPUT_BUS;
      sel.bus     = sel.code[7:5];
      sel.half    = sel.code[0] ^ ~sel.code[5];
      sel.channel = sel.code[4:0];
    end else begin
      // RULE14: fixed internal sources
      unique case (sel.code)
        CODE_CONVERTER0: sel.kind = INPUT_CONVERTER0;
        CODE_CONVERTER1: sel.kind = INPUT_CONVERTER1;
        CODE_LOWPOWER:   sel.kind = INPUT_LOWPOWER;
        CODE_DIV_B:      sel.kind = INPUT_DIV_B;
        CODE_DIV_A:      sel.kind = INPUT_DIV_A;
        CODE_SUPPLY:     sel.kind = INPUT_SUPPLY;
        CODE_GROUND:     sel.kind = INPUT_GROUND;
        // RULE17: undefined codes unsupported
        default:         sel.kind = INPUT_UNDEFINED;
      endcase
    end
  end

endmodule

// [test/comparator_input_select_regs_test.sv]
`timescale 1ns/1ps
// Self-checking bench for the comparator register bank; it drives the register bus and the analog-side inputs.
module comparator_input_select_regs_test;
  import comparator_pkg::*;

  logic        refClk       = 1'b0;      // 10 MHz clock.
  logic        resetN       = 1'b0;      // Active-low reset.
  logic        wbCyc        = 1'b0;      // Bus cycle.
  logic        wbStb        = 1'b0;      // Bus strobe.
  logic        wbWe         = 1'b0;      // Write enable.
  logic [7:0]  wbAdr        = 8'h00;     // Byte address.
  logic [3:0]  wbSel        = 4'h0;      // Byte lanes.
  logic [31:0] wbDat        = 32'h0000_0000; // Write data.
  logic        rawIn        = 1'b0;      // Analog comparator result.
  logic        readyIn      = 1'b0;      // Analog side warmed up.
  logic [9:0]  otherReq     = '0;        // Halves requested by other peripherals.
  wire  [31:0] wbRdat;
  wire         wbAck, irqOut, enOut, resOut, pinOut, bDiv, lpSel, csEn;
  wire  [9:0]  busReq;
  wire  [7:0]  positive_input_select, negative_input_select;
  wire  [5:0]  aDiv;
  wire  [2:0]  csSel;
  int          errCount     = 0;         // Mismatches seen.
  int          testsRun     = 0;         // Comparisons made.
  logic [31:0] rd, v, c;                 // Read data and random register images.
  logic        act, res;                 // Expected activity and result.

  // The half-period toggle gives a 100 ns period.
  always #50 refClk = ~refClk;

  comparator_input_select_regs u_dut (
    .ref_clk(refClk), .reset_n(resetN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbRdat), .wb_ack_o(wbAck),
    .irq(irqOut), .comparatorRaw(rawIn), .comparatorReady(readyIn), .otherRequest(otherReq),
    .busRequest(busReq), .positiveInputSelect(positive_input_select), .negativeInputSelect(negative_input_select),
    .aDividerSource(aDiv), .bDividerSource(bDiv), .lowpowerSampleSource(lpSel),
    .capsenseResistorEnable(csEn), .capsenseResistorSelect(csSel), .comparatorEnable(enOut),
    .comparatorResult(resOut), .pinOutput(pinOut)
  );

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One classic single cycle; the request holds until ack is sampled high, so no latency is assumed.
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rdat);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDat <= dat;
    do begin
      @(posedge refClk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) check(1'b0, 1'b1);
    rdat = wbRdat;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    @(posedge refClk);
  endtask

  // Lets level outputs settle after a register or input change.
  task automatic settle();
    repeat (4) @(posedge refClk);
  endtask

  // Bus half that a select code names, one-hot by bus*2+half; other codes name none.
  function automatic logic [9:0] halfBit(input logic [7:0] code);
    if (code <= 8'h1F) return 10'd1 << code[4];
    if (code <= 8'h9F) return 10'd1 << {code[7:5], code[0] ^ ~code[5]};
    return '0;
  endfunction

  // Halves this comparator should master under the given control image.
  function automatic logic [9:0] expReq(input logic [31:0] sel, input logic [31:0] ctl);
    logic [9:0] r;
    r = halfBit(sel[7:0]) | halfBit(sel[15:8]);
    return ctl[0] ? (r & ~ctl[17:8]) : '0;
  endfunction

  // Watchdog: far beyond the roughly 855 cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge refClk);
    errCount++;
    conclude();
  end

  // Main sequence.
  initial begin
    void'($urandom(21195));
    repeat (20) @(posedge refClk);
    resetN <= 1'b1;
    @(posedge refClk);
    wbXfer(1'b0, CTRL_OFFSET, '0, rd);
    check(rd, CTRL_RESET);
    wbXfer(1'b0, INPUT_SELECT_OFFSET, '0, rd);
    check(rd, INPUT_RESET);
    wbXfer(1'b0, STATUS_OFFSET, '0, rd);
    check(rd, 32'h0000_0000);
    // Random register images; reserved bits are written as zero.
    for (int i = 0; i < 40; i++) begin
      v = $urandom & INPUT_WRITE_MASK;
      c = $urandom & CTRL_WRITE_MASK;
      if (i < 4) v[15:0] = {8'h40 + 8'(i), 8'h1F - 8'(i)};
      if (i == 4) v[15:0] = 16'hF2FF;
      if (i == 5) v[15:0] = 16'hA0F2;
      rawIn   <= 1'($urandom);
      readyIn <= 1'($urandom);
      wbXfer(1'b1, INPUT_SELECT_OFFSET, v, rd);
      wbXfer(1'b1, CTRL_OFFSET, c, rd);
      settle();
      act = c[ENABLE_BIT] & readyIn;
      res = act ? rawIn : c[INACTIVE_BIT];
      wbXfer(1'b0, INPUT_SELECT_OFFSET, '0, rd);
      check(rd, v);
      check({1'b0, csSel, 1'b0, csEn, 1'b0, lpSel, 1'b0, bDiv, aDiv, negative_input_select, positive_input_select}, v);
      wbXfer(1'b0, CTRL_OFFSET, '0, rd);
      check(rd, c);
      check(enOut, c[ENABLE_BIT]);
      check(busReq, expReq(v, c));
      check(resOut, res);
      check(pinOut, res ^ c[INVERT_BIT]);
      wbXfer(1'b0, STATUS_OFFSET, '0, rd);
      check(rd, {30'b0, res, act});
    end
    // Warm-up, edge and conflict events with the interrupt masked in and then cleared.
    rawIn   <= 1'b0;
    readyIn <= 1'b0;
    wbXfer(1'b1, INPUT_SELECT_OFFSET, 32'h0000_4020, rd);
    wbXfer(1'b1, CTRL_OFFSET, 32'h0000_0001, rd);
    wbXfer(1'b1, FLAG_OFFSET, 32'h0000_0007, rd);
    wbXfer(1'b0, FLAG_OFFSET, '0, rd);
    check(rd, 32'h0000_0000);
    wbXfer(1'b1, MASK_OFFSET, 32'h0000_0007, rd);
    check(irqOut, 1'b0);
    readyIn <= 1'b1;
    settle();
    rawIn <= 1'b1;
    settle();
    check(busReq, 10'h024);
    check(irqOut, 1'b1);
    wbXfer(1'b0, FLAG_OFFSET, '0, rd);
    check(rd, 32'h0000_0003);
    otherReq <= 10'h020;
    settle();
    wbXfer(1'b0, STATUS_OFFSET, '0, rd);
    check(rd, 32'h0000_0007);
    wbXfer(1'b0, CONFLICT_OFFSET, '0, rd);
    check(rd, 32'h0000_0020);
    // Disabling mastering of the negative input's half drops the request and the conflict.
    wbXfer(1'b1, CTRL_OFFSET, 32'h0000_2001, rd);
    settle();
    check(busReq, 10'h004);
    wbXfer(1'b1, FLAG_OFFSET, 32'h0000_0007, rd);
    wbXfer(1'b0, FLAG_OFFSET, '0, rd);
    check(rd, 32'h0000_0000);
    check(irqOut, 1'b0);
    wbXfer(1'b0, STATUS_OFFSET, '0, rd);
    check(rd, 32'h0000_0003);
    // Unmapped places read as zero.
    wbXfer(1'b0, 8'h3C, '0, rd);
    check(rd, 32'h0000_0000);
    // A reset in mid-run brings every register and output back to its reset value.
    resetN <= 1'b0;
    repeat (3) @(posedge refClk);
    resetN <= 1'b1;
    @(posedge refClk);
    check(busReq, 10'h000);
    check(irqOut, 1'b0);
    wbXfer(1'b0, CTRL_OFFSET, '0, rd);
    check(rd, CTRL_RESET);
    wbXfer(1'b0, INPUT_SELECT_OFFSET, '0, rd);
    check(rd, INPUT_RESET);
    check(resOut, 1'b0);
    conclude();
  end
endmodule
